//--- ddr_ball_if.sv
// Purpose: Device-side control and data ball logic of a DRAM byte lane
// Assumes: Pins are synchronous to CK; MCLK side catches the strap, watches and counts
// Notes:   RESET_N acts on the CK side with no clock; MCLK side resets on RSTN

module ddr_ball_if (
    input  wire logic                          MCLK,      // Core clock
    input  wire logic                          RSTN,      // Core reset, sync, active low
    input  wire logic                          X8_MODE,   // Strap: high selects x8 balls
    input  wire logic                          CK,        // Link clock from controller
    input  wire logic                          RESET_N,   // Device reset, async, active low
    input  wire logic                          CS_N,      // Chip select, active low
    input  wire logic                          RAS_N,     // Row strobe, active low
    input  wire logic                          CAS_N,     // Column strobe, active low
    input  wire logic                          WE_N,      // Write strobe, active low
    input  wire logic                          ODT,       // Termination request
    input  wire logic [ddr_ball_pkg::ADDR_W-1:0] A,       // Address / op-code
    input  wire logic [ddr_ball_pkg::BA_W-1:0]   BA,      // Bank / mode register select
    input  wire logic [ddr_ball_pkg::DQ_W-1:0]   DQ_I,    // Data pins in
    output logic      [ddr_ball_pkg::DQ_W-1:0]   DQ_O,    // Data pins out
    output logic      [ddr_ball_pkg::DQ_W-1:0]   DQ_OE_N, // Data drive enable, low drives
    input  wire logic                          DQS_I,     // Write strobe in
    output logic                               DQS_O,     // Read strobe out
    output logic                               DQS_N_O,   // Read strobe complement out
    output logic                               DQS_OE_N,  // Strobe drive enable, low drives
    input  wire logic                          DM_I,      // Write mask ball
    output ddr_ball_pkg::term_t                TERM,      // Termination enables per ball
    output logic                               TERM_STATUS, // Termination on, MCLK side
    output logic                               LINK_IN_RESET, // Device reset seen, MCLK side
    output logic      [ddr_ball_pkg::CNT_W-1:0]  WR_COUNT, // Completed writes
    output logic      [ddr_ball_pkg::CNT_W-1:0]  RD_COUNT  // Completed reads
);

    // ---------------- CK domain ----------------
    ddr_ball_pkg::cmd_pins_t         cmd_q;
    logic [ddr_ball_pkg::ADDR_W-1:0] a_q;
    logic [ddr_ball_pkg::BA_W-1:0]   ba_q;
    logic                            odt_q;

    logic                            x8_ck;
    logic                            x8_core_q;
    logic                            cmd_valid;
    ddr_ball_pkg::cmd_t              cmd;
    logic [ddr_ball_pkg::DQ_W-1:0]   lanes;

    logic                            rtt_en_q;
    logic                            rtt_en_d;
    logic                            tdqs_en_q;
    logic                            tdqs_en_d;
    logic                            tdqs_on;
    logic                            term_on;
    ddr_ball_pkg::term_t             term_q;
    ddr_ball_pkg::term_t             term_d;

    ddr_ball_pkg::link_st_t          st_q;
    ddr_ball_pkg::link_st_t          st_d;
    logic [ddr_ball_pkg::IDX_W-1:0]  idx_q;
    logic [ddr_ball_pkg::IDX_W-1:0]  idx_d;
    logic [ddr_ball_pkg::DQ_W-1:0]   dq_o_q;
    logic [ddr_ball_pkg::DQ_W-1:0]   dq_o_d;
    logic [ddr_ball_pkg::DQ_W-1:0]   dq_oe_n_q;
    logic [ddr_ball_pkg::DQ_W-1:0]   dq_oe_n_d;
    logic                            dqs_o_q;
    logic                            dqs_o_d;
    logic                            dqs_oe_n_q;
    logic                            dqs_oe_n_d;
    logic                            wr_tgl_q;
    logic                            wr_tgl_d;
    logic                            rd_tgl_q;
    logic                            rd_tgl_d;
    logic                            wr_go;
    logic                            masked;
    logic [ddr_ball_pkg::DQ_W-1:0]   wr_word;

    logic [ddr_ball_pkg::DQ_W-1:0]   mem_q [ddr_ball_pkg::DEPTH];
    logic [ddr_ball_pkg::DQ_W-1:0]   mem_d [ddr_ball_pkg::DEPTH];

    // Pins are taken on the rising CK edge only
    always_ff @(posedge CK or negedge RESET_N) begin
        if (!RESET_N) begin
            cmd_q <= ddr_ball_pkg::CMD_PINS_IDLE;
            a_q   <= '0;
            ba_q  <= '0;
            odt_q <= 1'b0;
        end else begin
            cmd_q <= '{cs_n: CS_N, ras_n: RAS_N, cas_n: CAS_N, we_n: WE_N};
            a_q   <= A;
            ba_q  <= BA;
            odt_q <= ODT;
        end
    end

    ddr_sync2 #(.W(1)) u_x8_ck (
        .clk   (CK),
        .rst_n (RESET_N),
        .d     (x8_core_q),
        .q     (x8_ck)
    );

    always_comb begin
        cmd_valid = !cmd_q.cs_n;
        cmd       = ddr_ball_pkg::cmd_t'(cmd_q);
        lanes     = x8_ck ? ddr_ball_pkg::LANES_X8 : ddr_ball_pkg::LANES_X4;
        tdqs_on   = tdqs_en_q && x8_ck;
        term_on   = odt_q && rtt_en_q;
    end

    // Mode and termination group
    always_comb begin
        rtt_en_d  = rtt_en_q;
        tdqs_en_d = tdqs_en_q;
        if (cmd_valid && cmd == ddr_ball_pkg::CMD_LOAD_MODE
            && ba_q == ddr_ball_pkg::MR_TERM_SEL) begin
            rtt_en_d  = a_q[ddr_ball_pkg::MR_RTT_BIT];
            tdqs_en_d = a_q[ddr_ball_pkg::MR_TDQS_BIT];
        end
        term_d = ddr_ball_pkg::TERM_OFF;
        if (term_on) begin
            term_d.dq   = lanes;
            term_d.dqs  = 1'b1;
            term_d.dm   = 1'b1;
            term_d.tdqs = tdqs_on;
        end
    end

    always_ff @(posedge CK or negedge RESET_N) begin
        if (!RESET_N) begin
            rtt_en_q  <= ddr_ball_pkg::MR_RTT_RST;
            tdqs_en_q <= ddr_ball_pkg::MR_TDQS_RST;
            term_q    <= ddr_ball_pkg::TERM_OFF;
        end else begin
            rtt_en_q  <= rtt_en_d;
            tdqs_en_q <= tdqs_en_d;
            term_q    <= term_d;
        end
    end

    // Write beat: strobe present qualifies the data; mask gives way to TDQS
    always_comb begin
        wr_go   = (st_q == ddr_ball_pkg::ST_WR) && DQS_I;
        masked  = DM_I && !tdqs_on;
        wr_word = (mem_q[idx_q] & ~lanes) | (DQ_I & lanes);
    end

    for (genvar i = 0; i < ddr_ball_pkg::DEPTH; i++) begin : g_mem
        always_comb begin
            mem_d[i] = mem_q[i];
            if (wr_go && !masked && idx_q == ddr_ball_pkg::IDX_W'(i)) begin
                mem_d[i] = wr_word;
            end
        end

        always_ff @(posedge CK or negedge RESET_N) begin
            if (!RESET_N) begin
                mem_q[i] <= '0;
            end else begin
                mem_q[i] <= mem_d[i];
            end
        end
    end

    // Access sequencer: one data beat per access
    always_comb begin
        st_d       = st_q;
        idx_d      = idx_q;
        dq_o_d     = '0;
        dq_oe_n_d  = '1;
        dqs_o_d    = 1'b0;
        dqs_oe_n_d = 1'b1;
        wr_tgl_d   = wr_tgl_q;
        rd_tgl_d   = rd_tgl_q;
        unique case (st_q)
            ddr_ball_pkg::ST_IDLE: begin
                if (cmd_valid && cmd == ddr_ball_pkg::CMD_WRITE) begin
                    st_d  = ddr_ball_pkg::ST_WR;
                    idx_d = a_q[ddr_ball_pkg::IDX_W-1:0];
                end else if (cmd_valid && cmd == ddr_ball_pkg::CMD_READ) begin
                    st_d       = ddr_ball_pkg::ST_RD;
                    idx_d      = a_q[ddr_ball_pkg::IDX_W-1:0];
                    // Data and strobe launch from the same edge
                    dq_o_d     = mem_q[a_q[ddr_ball_pkg::IDX_W-1:0]] & lanes;
                    dq_oe_n_d  = ~lanes;
                    dqs_o_d    = 1'b1;
                    dqs_oe_n_d = 1'b0;
                end
            end
            ddr_ball_pkg::ST_WR: begin
                // Without a strobe the beat is lost; the access still ends
                st_d     = ddr_ball_pkg::ST_IDLE;
                wr_tgl_d = ~wr_tgl_q;
            end
            ddr_ball_pkg::ST_RD: begin
                st_d     = ddr_ball_pkg::ST_IDLE;
                rd_tgl_d = ~rd_tgl_q;
            end
            default: begin
                st_d = ddr_ball_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CK or negedge RESET_N) begin
        if (!RESET_N) begin
            st_q       <= ddr_ball_pkg::ST_IDLE;
            idx_q      <= '0;
            dq_o_q     <= '0;
            dq_oe_n_q  <= '1;
            dqs_o_q    <= 1'b0;
            dqs_oe_n_q <= 1'b1;
            wr_tgl_q   <= 1'b0;
            rd_tgl_q   <= 1'b0;
        end else begin
            st_q       <= st_d;
            idx_q      <= idx_d;
            dq_o_q     <= dq_o_d;
            dq_oe_n_q  <= dq_oe_n_d;
            dqs_o_q    <= dqs_o_d;
            dqs_oe_n_q <= dqs_oe_n_d;
            wr_tgl_q   <= wr_tgl_d;
            rd_tgl_q   <= rd_tgl_d;
        end
    end

    always_comb begin
        DQ_O     = dq_o_q;
        DQ_OE_N  = dq_oe_n_q;
        DQS_O    = dqs_o_q;
        DQS_N_O  = ~dqs_o_q;
        DQS_OE_N = dqs_oe_n_q;
        TERM     = term_q;
    end

    // ---------------- MCLK domain ----------------
    logic                           x8_s;
    logic                           x8_core_d;
    logic                           strap_done_q;
    logic                           strap_done_d;
    logic                           term_s;
    logic                           rst_s;
    logic                           sync_live;
    logic                           wr_pulse;
    logic                           rd_pulse;
    logic [ddr_ball_pkg::CNT_W-1:0] wr_cnt_q;
    logic [ddr_ball_pkg::CNT_W-1:0] wr_cnt_d;
    logic [ddr_ball_pkg::CNT_W-1:0] rd_cnt_q;
    logic [ddr_ball_pkg::CNT_W-1:0] rd_cnt_d;
    logic                           term_st_q;
    logic                           in_rst_q;

    // The constant lane marks when the synchroniser output is past its reset value
    ddr_sync2 #(.W(4)) u_core_sync (
        .clk   (MCLK),
        .rst_n (RSTN),
        .d     ({X8_MODE, term_q.dqs, ~RESET_N, 1'b1}),
        .q     ({x8_s, term_s, rst_s, sync_live})
    );

    ddr_toggle_rx u_wr_rx (
        .clk   (MCLK),
        .rst_n (RSTN),
        .tgl   (wr_tgl_q),
        .pulse (wr_pulse)
    );

    ddr_toggle_rx u_rd_rx (
        .clk   (MCLK),
        .rst_n (RSTN),
        .tgl   (rd_tgl_q),
        .pulse (rd_pulse)
    );

    // Strap is caught once, after the synchroniser has filled, so usage never shifts
    always_comb begin
        x8_core_d    = x8_core_q;
        strap_done_d = strap_done_q;
        if (!strap_done_q && sync_live) begin
            x8_core_d    = x8_s;
            strap_done_d = 1'b1;
        end
        // A device reset clears the toggles; that edge is not an access
        wr_cnt_d = wr_cnt_q + ddr_ball_pkg::CNT_W'(wr_pulse && !rst_s);
        rd_cnt_d = rd_cnt_q + ddr_ball_pkg::CNT_W'(rd_pulse && !rst_s);
    end

    always_ff @(posedge MCLK) begin
        if (!RSTN) begin
            x8_core_q    <= 1'b0;
            strap_done_q <= 1'b0;
            wr_cnt_q     <= '0;
            rd_cnt_q     <= '0;
            term_st_q    <= 1'b0;
            in_rst_q     <= 1'b0;
        end else begin
            x8_core_q    <= x8_core_d;
            strap_done_q <= strap_done_d;
            wr_cnt_q     <= wr_cnt_d;
            rd_cnt_q     <= rd_cnt_d;
            term_st_q    <= term_s;
            in_rst_q     <= rst_s;
        end
    end

    always_comb begin
        TERM_STATUS   = term_st_q;
        LINK_IN_RESET = in_rst_q;
        WR_COUNT      = wr_cnt_q;
        RD_COUNT      = rd_cnt_q;
    end

endmodule

//--- ddr_ball_pkg.sv
// Purpose: Shared constants and types for the DRAM ball interface block
// Assumes: One byte lane, x4 or x8 ball usage chosen by a strap
// Notes:   Command codes are {cs_n, ras_n, cas_n, we_n} taken as one vector
package ddr_ball_pkg;

    localparam int DQ_W   = 8;
    localparam int ADDR_W = 14;
    localparam int BA_W   = 3;
    localparam int DEPTH  = 16;
    localparam int IDX_W  = 4;
    localparam int CNT_W  = 8;

    // Data lanes that are live in each ball usage
    localparam logic [DQ_W-1:0] LANES_X4 = 8'h0f;
    localparam logic [DQ_W-1:0] LANES_X8 = 8'hff;

    // Mode register that holds the termination and strobe-substitution bits
    localparam logic [BA_W-1:0] MR_TERM_SEL  = 3'h1;
    localparam int              MR_RTT_BIT   = 2;
    localparam int              MR_TDQS_BIT  = 11;
    localparam logic            MR_RTT_RST   = 1'b0;
    localparam logic            MR_TDQS_RST  = 1'b0;

    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
    } cmd_pins_t;

    localparam cmd_pins_t CMD_PINS_IDLE = 4'hf;

    typedef enum logic [3:0] {
        CMD_LOAD_MODE = 4'h0,
        CMD_REFRESH   = 4'h1,
        CMD_PRECHARGE = 4'h2,
        CMD_ACTIVATE  = 4'h3,
        CMD_WRITE     = 4'h4,
        CMD_READ      = 4'h5,
        CMD_ZQ_CAL    = 4'h6,
        CMD_NOP       = 4'h7
    } cmd_t;

    typedef struct packed {
        logic [DQ_W-1:0] dq;
        logic            dqs;
        logic            dm;
        logic            tdqs;
    } term_t;

    localparam term_t TERM_OFF = 11'h000;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WR   = 2'b01,
        ST_RD   = 2'b10
    } link_st_t;

endpackage

//--- ddr_sync2.sv
// Purpose: Two flip-flop synchroniser for levels
// Assumes: Input is a level that holds long enough to be seen
// Notes:   The first stage feeds only the second stage
module ddr_sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk,   // Destination clock
    input  wire logic         rst_n, // Destination reset, active low
    input  wire logic [W-1:0] d,     // Level from another domain
    output logic      [W-1:0] q      // Synchronised level
);

    logic [W-1:0] meta_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule

//--- ddr_toggle_rx.sv
// Purpose: Turns a toggle from another domain into a one-cycle pulse
// Assumes: Source toggles no faster than every three destination cycles
// Notes:   Synchronous active-low reset in the destination domain
module ddr_toggle_rx (
    input  wire logic clk,   // Destination clock
    input  wire logic rst_n, // Synchronous reset, active low
    input  wire logic tgl,   // Toggle from source domain
    output logic      pulse  // One cycle per source event
);

    logic meta_q;
    logic sync_q;
    logic last_q;
    logic meta_d;
    logic sync_d;
    logic last_d;

    always_comb begin
        meta_d = rst_n ? tgl : 1'b0;
        sync_d = rst_n ? meta_q : 1'b0;
        last_d = rst_n ? sync_q : 1'b0;
        pulse  = sync_q ^ last_q;
    end

    always_ff @(posedge clk) begin
        meta_q <= meta_d;
        sync_q <= sync_d;
        last_q <= last_d;
    end

endmodule

//--- ddr_ball_if_assertions.sv
// Purpose: Port-level checks on the DRAM ball interface block
// Assumes: CK side resets on RESET_N, core side on RSTN
// Notes:   Latency windows are loose where the hand-over leaves slack
module ddr_ball_if_assertions (
    input wire logic                            MCLK,          // Core clock
    input wire logic                            RSTN,          // Core reset
    input wire logic                            X8_MODE,       // Ball usage strap
    input wire logic                            CK,            // Link clock
    input wire logic                            RESET_N,       // Device reset
    input wire logic                            CS_N,          // Chip select
    input wire logic                            RAS_N,         // Row strobe
    input wire logic                            CAS_N,         // Column strobe
    input wire logic                            WE_N,          // Write strobe
    input wire logic                            ODT,           // Termination request
    input wire logic [ddr_ball_pkg::DQ_W-1:0]   DQ_OE_N,       // Data drive enables
    input wire logic                            DQS_O,         // Read strobe
    input wire logic                            DQS_N_O,       // Read strobe complement
    input wire logic                            DQS_OE_N,      // Strobe drive enable
    input wire ddr_ball_pkg::term_t             TERM,          // Termination enables
    input wire logic                            LINK_IN_RESET  // Reset seen on core side
);
    sequence s_rd_cmd;
        !CS_N && RAS_N && !CAS_N && WE_N && DQS_OE_N;
    endsequence
    sequence s_odt_low;
        !ODT [*3];
    endsequence
    property p_rd_issue;
        @(posedge CK) disable iff (!RESET_N) s_rd_cmd |-> ##[1:3] !DQS_OE_N;
    endproperty
    a_rd_issue: assert property (p_rd_issue) else $error("read not answered");
    property p_cs_gate;
        @(posedge CK) disable iff (!RESET_N)
            $fell(DQS_OE_N) |-> !$past(CS_N, 1) || !$past(CS_N, 2) || !$past(CS_N, 3);
    endproperty
    a_cs_gate: assert property (p_cs_gate) else $error("drive without select");
    property p_rd_strobe;
        @(posedge CK) disable iff (!RESET_N) !DQS_OE_N |-> DQS_O && !DQS_N_O;
    endproperty
    a_rd_strobe: assert property (p_rd_strobe) else $error("strobe pair wrong");
    property p_rd_stand;
        @(posedge CK) disable iff (!RESET_N) $fell(DQS_OE_N) |=> DQS_OE_N;
    endproperty
    a_rd_stand: assert property (p_rd_stand) else $error("strobe stood too long");
    property p_rd_edge;
        @(posedge CK) disable iff (!RESET_N) $changed(DQ_OE_N) |-> $changed(DQS_OE_N);
    endproperty
    a_rd_edge: assert property (p_rd_edge) else $error("data and strobe apart");
    property p_lanes;
        @(posedge CK) disable iff (!RESET_N)
            !X8_MODE |-> (&DQ_OE_N[7:4]) && TERM.dq[7:4] == 4'h0 && !TERM.tdqs;
    endproperty
    a_lanes: assert property (p_lanes) else $error("upper balls used in x4");
    property p_term_scope;
        @(posedge CK) disable iff (!RESET_N)
            TERM != ddr_ball_pkg::TERM_OFF |-> TERM.dqs && TERM.dm && TERM.dq[3:0] == 4'hf;
    endproperty
    a_term_scope: assert property (p_term_scope) else $error("termination scope");
    property p_term_off;
        @(posedge CK) disable iff (!RESET_N) s_odt_low |-> TERM == ddr_ball_pkg::TERM_OFF;
    endproperty
    a_term_off: assert property (p_term_off) else $error("termination stuck on");
    property p_in_reset;
        @(posedge MCLK) disable iff (!RSTN) !RESET_N [*4] |-> LINK_IN_RESET;
    endproperty
    a_in_reset: assert property (p_in_reset) else $error("reset not seen");
endmodule

bind ddr_ball_if ddr_ball_if_assertions i_chk (
    .MCLK(MCLK), .RSTN(RSTN), .X8_MODE(X8_MODE), .CK(CK), .RESET_N(RESET_N),
    .CS_N(CS_N), .RAS_N(RAS_N), .CAS_N(CAS_N), .WE_N(WE_N), .ODT(ODT),
    .DQ_OE_N(DQ_OE_N), .DQS_O(DQS_O), .DQS_N_O(DQS_N_O), .DQS_OE_N(DQS_OE_N),
    .TERM(TERM), .LINK_IN_RESET(LINK_IN_RESET)
);

//--- ddr_ctrl_model.sv
// Purpose: Memory controller model driving the device pins
// Assumes: Link clock runs free at 30 ns, single-beat accesses
// Notes:   Released address, bank and data lines show the inverse of their last value; command lines return to idle
module ddr_ctrl_model (
    output logic        CK,      // Link clock
    output logic        RESET_N, // Device reset
    output logic        CS_N,    // Chip select
    output logic        RAS_N,   // Row strobe
    output logic        CAS_N,   // Column strobe
    output logic        WE_N,    // Write strobe
    output logic        ODT,     // Termination request
    output logic [13:0] A,       // Address
    output logic [2:0]  BA,      // Bank select
    output logic [7:0]  DQ_I,    // Write data
    output logic        DQS_I,   // Write strobe
    output logic        DM_I     // Write mask
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        CK = 1'b0;
        #7;
        forever #15 CK = ~CK;
    end
    initial begin
        RESET_N = 1'b0;
        {CS_N, RAS_N, CAS_N, WE_N} = 4'hf;
        ODT = 1'b0;
        A = 14'h0000;
        BA = 3'h0;
        DQ_I = 8'h00;
        DQS_I = 1'b0;
        DM_I = 1'b0;
    end
    task automatic issue(input logic [3:0] c, input logic [13:0] a, input logic [2:0] b);
        @(posedge CK);
        {CS_N, RAS_N, CAS_N, WE_N} <= c;
        A <= a;
        BA <= b;
        @(posedge CK);
        {CS_N, RAS_N, CAS_N, WE_N} <= 4'hf;
        A <= ~a;
        BA <= ~b;
    endtask
    task automatic put_data(input logic [7:0] d, input logic dm);
        @(posedge CK);
        DQ_I <= d;
        DM_I <= dm;
        DQS_I <= 1'b1;
        @(posedge CK);
        DQ_I <= ~d;
        DM_I <= ~dm;
        DQS_I <= 1'b0;
        @(posedge CK);
    endtask
    task automatic set_odt(input logic v);
        @(posedge CK);
        ODT <= v;
    endtask
    task automatic set_rst(input logic v);
        @(posedge CK);
        #4;
        RESET_N <= v; // Off-edge on purpose: reset must act without CK
    endtask
endmodule

//--- tb_ddr_ball_if.sv
// Purpose: Self-checking bench for the DRAM ball interface block
// Assumes: Commands spaced at least four CK cycles apart
// Notes:   Both ball usages run, each after a full reset
module tb_ddr_ball_if;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk, rstn, x8_mode, ck, reset_n, cs_n, ras_n, cas_n, we_n, odt;
    logic [13:0] a;
    logic [2:0]  ba;
    logic [7:0]  dq_i, dq_o, dq_oe_n, wr_count, rd_count, ln;
    logic        dqs_i, dqs_o, dqs_n_o, dqs_oe_n, dm_i, term_status, link_in_reset;
    logic        en_on, sub_on;
    ddr_ball_pkg::term_t term;
    int          errors, comparisons, seed, wr_n, rd_n;
    logic [7:0]  mem [16];
    ddr_ball_if i_ddr_ball_if (.MCLK(mclk), .RSTN(rstn), .X8_MODE(x8_mode), .CK(ck),
        .RESET_N(reset_n), .CS_N(cs_n), .RAS_N(ras_n), .CAS_N(cas_n), .WE_N(we_n),
        .ODT(odt), .A(a), .BA(ba), .DQ_I(dq_i), .DQ_O(dq_o), .DQ_OE_N(dq_oe_n),
        .DQS_I(dqs_i), .DQS_O(dqs_o), .DQS_N_O(dqs_n_o), .DQS_OE_N(dqs_oe_n),
        .DM_I(dm_i), .TERM(term), .TERM_STATUS(term_status),
        .LINK_IN_RESET(link_in_reset), .WR_COUNT(wr_count), .RD_COUNT(rd_count));
    ddr_ctrl_model i_ddr_ctrl_model (.CK(ck), .RESET_N(reset_n), .CS_N(cs_n),
        .RAS_N(ras_n), .CAS_N(cas_n), .WE_N(we_n), .ODT(odt), .A(a), .BA(ba),
        .DQ_I(dq_i), .DQS_I(dqs_i), .DM_I(dm_i));
    always #20 mclk = ~mclk;
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    function automatic logic [15:0] term_exp();
        if (en_on && odt) return {5'h00, ln, 2'b11, x8_mode & sub_on};
        return 16'h0000;
    endfunction
    task automatic load(input logic en, input logic sub);
        i_ddr_ctrl_model.issue(4'h0, {2'b00, sub, 8'h00, en, 2'b00}, 3'h1);
        en_on = en;
        sub_on = sub;
        repeat (3) @(posedge ck);
    endtask
    task automatic odt_chk(input logic v);
        i_ddr_ctrl_model.set_odt(v);
        repeat (4) @(posedge ck);
        check({5'h00, term}, term_exp());
    endtask
    task automatic wr(input int idx, input logic [7:0] d, input logic dm, input logic cs);
        i_ddr_ctrl_model.issue({cs, 3'b100}, 14'(idx), 3'h0);
        i_ddr_ctrl_model.put_data(d, dm);
        if (!cs) begin
            wr_n++;
            if (!(dm && !(x8_mode && sub_on))) mem[idx] = d & ln;
        end
    endtask
    task automatic read_chk(input int idx);
        int k;
        i_ddr_ctrl_model.issue(4'h5, 14'(idx), 3'h0);
        k = 0;
        while (dqs_oe_n !== 1'b0 && k < 8) begin
            @(negedge ck);
            k++;
        end
        if (k == 8) begin
            errors++;
            $display("[ERR] %0t read strobe never came", $time);
            complete_run();
        end
        check(dq_o, mem[idx]);
        check(dq_oe_n, {~ln});
        check({dqs_o, dqs_n_o}, 2'b10);
        rd_n++;
        @(posedge ck);
    endtask
    initial begin
        int m, i;
        logic [7:0] d;
        mclk = 1'b0;
        rstn = 1'b0;
        x8_mode = 1'b0;
        seed = 84;
        for (m = 0; m < 2; m++) begin
            i_ddr_ctrl_model.set_rst(1'b0);
            @(posedge mclk);
            x8_mode <= m[0];
            rstn <= 1'b0;
            repeat (20) @(posedge mclk);
            rstn <= 1'b1;
            i_ddr_ctrl_model.set_rst(1'b1);
            repeat (10) @(posedge ck);
            ln = x8_mode ? ddr_ball_pkg::LANES_X8 : ddr_ball_pkg::LANES_X4;
            en_on = 1'b0;
            sub_on = 1'b0;
            wr_n = 0;
            rd_n = 0;
            foreach (mem[j]) mem[j] = 8'h00;
            odt_chk(1'b1);
            load(1'b1, 1'b0);
            odt_chk(1'b1);
            repeat (6) @(posedge mclk);
            check(term_status, 1'b1);
            odt_chk(1'b0);
            for (i = 0; i < 8; i++) begin
                d = 8'($random(seed));
                wr(i * 2, d, 1'b0, 1'b0);
                d = 8'($random(seed));
                wr(i * 2, d, d[0], i == 5);
            end
            for (i = 0; i < 8; i++) read_chk(i * 2);
            load(1'b1, 1'b1);
            odt_chk(1'b1);
            wr(3, 8'h5a, 1'b0, 1'b0);
            wr(3, 8'ha5, 1'b1, 1'b0);
            read_chk(3);
            load(1'b0, 1'b1);
            repeat (4) @(posedge ck);
            check({5'h00, term}, 16'h0000);
            load(1'b1, 1'b0);
            repeat (4) @(posedge ck);
            i_ddr_ctrl_model.set_rst(1'b0);
            #1;
            check({5'h00, term}, 16'h0000);
            check(dqs_oe_n, 1'b1);
            repeat (10) @(posedge mclk);
            check(link_in_reset, 1'b1);
            check(wr_count, 8'(wr_n));
            check(rd_count, 8'(rd_n));
            $display("test in ball usage %0d done", m);
        end
        complete_run();
    end
endmodule
